// ===== hdl/group_decoder.sv
// Purpose: Locates a register number inside one thumbwheel-selected register group
// Assumes: Thumbwheel value 0 to 99
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module group_decoder
  import process_image_pkg::*;
#(
  parameter logic [16:0] BASE = INPUT_REG_BASE
) (
  input  wire logic [16:0]            i_register_number,
  input  wire logic [THUMB_WIDTH-1:0] i_thumbwheel,
  output logic                        o_hit,
  output logic [3:0]                  o_index
);

  logic [16:0] group_start;
  logic [16:0] offset;

  // Group start is base plus ten times the thumbwheel setting
  assign group_start = BASE + 17'(i_thumbwheel * GROUP_STRIDE);
  assign offset      = i_register_number - group_start;
  assign o_hit       = (i_register_number >= group_start) && (offset < 17'(GROUP_SIZE));
  assign o_index     = offset[3:0];

endmodule // group_decoder
`default_nettype wire

// ===== hdl/output_module_process_image.sv
// Purpose: Process image of a relay (4 channel) or transistor (8 channel) output module
// Assumes: One register per request; module kind strap stable after reset
// Notes:   Summary of operation follows
//
// Summary of operation
// - The register group starts at base plus ten times the thumbwheel group index.
// - The status word carries the not-current flag in bit 8 and the module type in the low byte.
// - The not-current flag reads 1 while the held data is not up to date.
// - On the relay module a process data write to any module register clears the flag.
// - Once cleared by a write the relay flag stays 0 until the next reset.
// - On the eight-channel module a write clears bit 8 of the holding status word for good.
// - Eight-channel module: bit 8 of the input status word is 1 while short status is stale.
// - On the eight-channel module loss of communication with the partner input module makes the input data not current.
// - While not current the last input values stay readable but are no longer refreshed.
// - The module type field reads 0 whenever the module type is invalid or unavailable.
// - Bit 1 of the short-circuit word is set on a short at any of channels five to eight.
// - Bit 0 of the short-circuit word is set on a short at any of channels one to four.
`timescale 1ns/1ps
`default_nettype none
module output_module_process_image
  import process_image_pkg::*;
#(
  parameter logic [7:0] RELAY_TYPE_ID = 8'hA1, // Arbitrary value
  parameter logic [7:0] OCTAL_TYPE_ID = 8'hA2  // Arbitrary value
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_resetn,
  input  wire logic [THUMB_WIDTH-1:0] i_thumbwheel,
  input  wire logic                   i_module_select,
  input  wire logic                   i_module_type_valid,
  input  wire logic                   i_link_ok,
  input  wire logic [7:0]             i_short_circuit,
  input  wire request_s               i_request,
  output var  response_s              o_response,
  output logic [7:0]                  o_output_channels
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic       kind_latched;
    logic       kind_octal;
    logic       holding_stale;
    logic       input_stale;
    logic [1:0] short_word;
    logic [7:0] output_word;
    response_s  response;
  } state_s;

  state_s state;
  state_s next_state;

  logic       input_hit;
  logic [3:0] input_index;
  logic       holding_hit;
  logic [3:0] holding_index;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  group_decoder #(
    .BASE (INPUT_REG_BASE)
  ) u_input_decoder (
    .i_register_number (i_request.register_number),
    .i_thumbwheel      (i_thumbwheel),
    .o_hit             (input_hit),
    .o_index           (input_index)
  );

  group_decoder #(
    .BASE (HOLDING_REG_BASE)
  ) u_holding_decoder (
    .i_register_number (i_request.register_number),
    .i_thumbwheel      (i_thumbwheel),
    .o_hit             (holding_hit),
    .o_index           (holding_index)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       octal;
    logic [7:0] type_field;
    logic [7:0] out_mask;
    logic [15:0] status_holding;
    logic [15:0] status_input;
    octal          = state.kind_latched ? state.kind_octal : i_module_select;
    type_field     = 8'h00;
    out_mask       = octal ? OCTAL_OUT_MASK : RELAY_OUT_MASK;
    status_holding = 16'h0000;
    status_input   = 16'h0000;
    next_state     = state;

    // Strap is caught on the first edge after reset release
    next_state.kind_latched = 1'b1;
    next_state.kind_octal   = octal;

    if (i_module_type_valid) begin
      type_field = octal ? OCTAL_TYPE_ID : RELAY_TYPE_ID;
    end else begin
      type_field = 8'h00;
    end

    status_holding[7:0]       = type_field;
    status_holding[STALE_BIT] = state.holding_stale;
    status_input[7:0]         = type_field;
    if (octal) begin
      status_input[STALE_BIT] = state.input_stale;
    end else begin
      status_input[STALE_BIT] = state.holding_stale;
    end

    // Short-circuit status follows the partner only while the link is up
    next_state.input_stale = ~i_link_ok;
    if (i_link_ok) begin
      next_state.short_word[SHORT_HIGH_BIT] = |i_short_circuit[7:4];
      next_state.short_word[SHORT_LOW_BIT]  = |i_short_circuit[3:0];
    end else begin
      next_state.short_word = state.short_word;
    end

    next_state.response.valid     = 1'b0;
    next_state.response.exception = 1'b0;
    next_state.response.data      = DATA_RESET;

    if (i_request.valid) begin
      next_state.response.valid = 1'b1;
      unique case (i_request.function_code)
        FC_READ_INPUT: begin
          if (input_hit) begin
            if (input_index == STATUS_INDEX) begin
              next_state.response.data = status_input;
            end else if ((input_index == DATA_INDEX) && octal) begin
              next_state.response.data = {14'h0000, state.short_word};
            end else begin
              next_state.response.data = DATA_RESET;
            end
          end else begin
            next_state.response.exception = 1'b1;
            next_state.response.data      = EXC_ILLEGAL_ADDR;
          end
        end
        FC_READ_HOLDING: begin
          if (holding_hit) begin
            if (holding_index == STATUS_INDEX) begin
              next_state.response.data = status_holding;
            end else if (holding_index == DATA_INDEX) begin
              next_state.response.data = {8'h00, state.output_word};
            end else begin
              next_state.response.data = DATA_RESET;
            end
          end else begin
            next_state.response.exception = 1'b1;
            next_state.response.data      = EXC_ILLEGAL_ADDR;
          end
        end
        FC_WRITE_MULTI: begin
          if (holding_hit) begin
            // Any write into the group clears the holding stale flag for good
            next_state.holding_stale = 1'b0;
            if (holding_index == DATA_INDEX) begin
              next_state.output_word = i_request.write_data[7:0] & out_mask;
            end
            next_state.response.data = i_request.write_data;
          end else begin
            next_state.response.exception = 1'b1;
            next_state.response.data      = EXC_ILLEGAL_ADDR;
          end
        end
        default: begin
          next_state.response.exception = 1'b1;
          next_state.response.data      = EXC_ILLEGAL_FUNC;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state.kind_latched       <= 1'b0;
      state.kind_octal         <= 1'b0;
      state.holding_stale      <= STALE_RESET;
      state.input_stale        <= STALE_RESET;
      state.short_word         <= SHORT_RESET;
      state.output_word        <= OUTPUT_RESET;
      state.response.valid     <= 1'b0;
      state.response.exception <= 1'b0;
      state.response.data      <= DATA_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_response        = state.response;
  assign o_output_channels = state.output_word;

endmodule // output_module_process_image
`default_nettype wire

// ===== hdl/process_image_pkg.sv
// Purpose: Shared constants and carriers for the output module process image
// Assumes: Register numbers are carried as plain binary values of the decimal register number
// Notes:   Module type identifiers are parameters of the top module
`default_nettype none
package process_image_pkg;

  // ****************************************************************
  // Register numbering
  // ****************************************************************
  localparam logic [16:0] INPUT_REG_BASE   = 17'h07530; // 30000
  localparam logic [16:0] HOLDING_REG_BASE = 17'h09C40; // 40000
  localparam logic [16:0] GROUP_STRIDE     = 17'h0000A; // 10 registers per group
  localparam logic [3:0]  GROUP_SIZE       = 4'hA;
  localparam logic [3:0]  STATUS_INDEX     = 4'h0;
  localparam logic [3:0]  DATA_INDEX       = 4'h1;
  localparam int          THUMB_WIDTH      = 7;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int          STALE_BIT        = 8;
  localparam int          SHORT_LOW_BIT    = 0;
  localparam int          SHORT_HIGH_BIT   = 1;
  localparam logic [7:0]  RELAY_OUT_MASK   = 8'h0F;
  localparam logic [7:0]  OCTAL_OUT_MASK   = 8'hFF;

  // ****************************************************************
  // Function codes and exception codes
  // ****************************************************************
  localparam logic [7:0]  FC_READ_HOLDING  = 8'h03;
  localparam logic [7:0]  FC_READ_INPUT    = 8'h04;
  localparam logic [7:0]  FC_WRITE_MULTI   = 8'h10;
  localparam logic [15:0] EXC_ILLEGAL_FUNC = 16'h0001;
  localparam logic [15:0] EXC_ILLEGAL_ADDR = 16'h0002;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        STALE_RESET      = 1'b1;
  localparam logic [7:0]  OUTPUT_RESET     = 8'h00;
  localparam logic [1:0]  SHORT_RESET      = 2'h0;
  localparam logic [15:0] DATA_RESET       = 16'h0000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic [7:0]  function_code;
    logic [16:0] register_number;
    logic [15:0] write_data;
  } request_s;

  typedef struct packed {
    logic        valid;
    logic        exception;
    logic [15:0] data;
  } response_s;

endpackage
`default_nettype wire

// ===== sim/modbus_master_model.sv
// Purpose: Register master issuing one request per transfer
// Assumes: Answer stands in the cycle after the taking edge
// Notes:   Fields scrambled while idle
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model
  import process_image_pkg::*;
(
  input  wire logic      i_clock,
  input  wire response_s i_response,
  output var  request_s  o_request
);
  initial o_request = '0;
  task automatic xfer(input logic [7:0] fc, input logic [16:0] rn,
                      input logic [15:0] wd, output response_s r);
    @(posedge i_clock) #1;
    o_request = {1'b1, fc, rn, wd};
    @(posedge i_clock) #1;
    o_request = {1'b0, ~fc, ~rn, ~wd};
    r = i_response;
  endtask
endmodule // modbus_master_model
`default_nettype wire

// ===== sim/output_module_process_image_tb.sv
// Purpose: Self-checking bench for the output module process image
// Assumes: Reference model updated as inputs change
// Notes:   Type identifiers are arbitrary
`timescale 1ns/1ps
`default_nettype none
module output_module_process_image_tb
  import process_image_pkg::*;
;
  localparam logic [7:0] REL_ID = 8'h5C; // Arbitrary value
  localparam logic [7:0] OCT_ID = 8'h6D; // Arbitrary value
  logic        i_clock, i_resetn, i_module_select, i_module_type_valid, i_link_ok;
  logic [6:0]  i_thumbwheel;
  logic [7:0]  i_short_circuit, o_output_channels;
  request_s    i_request;
  response_s   o_response;
  logic [31:0] seed = 32'h732FA93D;
  logic        stl_h, oct, lnk, tv;
  logic [15:0] outw, sw;
  int          th, err_count, checks_done;
  output_module_process_image #(.RELAY_TYPE_ID(REL_ID), .OCTAL_TYPE_ID(OCT_ID))
    output_module_process_image_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_thumbwheel(i_thumbwheel), .i_module_select(i_module_select),
    .i_module_type_valid(i_module_type_valid), .i_link_ok(i_link_ok),
    .i_short_circuit(i_short_circuit), .i_request(i_request),
    .o_response(o_response), .o_output_channels(o_output_channels));
  modbus_master_model modbus_master_model_inst (.i_clock(i_clock),
    .i_response(o_response), .o_request(i_request));
  // ******
  // Model and helpers
  // ******
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int hb(input int n); return 40000 + 10 * th + n; endfunction
  function automatic int ib(input int n); return 30000 + 10 * th + n; endfunction
  function automatic logic [16:0] model(input logic [7:0] fc, input int rn, input logic [15:0] wd);
    int k;
    logic [15:0] st;
    k = rn - (fc == 8'h04 ? ib(0) : hb(0));
    st = {7'h00, stl_h, tv ? (oct ? OCT_ID : REL_ID) : 8'h00};
    if (!(fc inside {8'h03, 8'h04, 8'h10})) return 17'h10001;
    if (k < 0 || k > 9) return 17'h10002;
    if (fc == 8'h10) begin
      if (k == 1) outw = wd & (oct ? 16'h00FF : 16'h000F);
      stl_h = 1'b0;
      return {1'b0, wd};
    end
    if (fc == 8'h03) return {1'b0, k == 0 ? st : k == 1 ? outw : 16'h0000};
    if (oct) st[8] = !lnk;
    return {1'b0, k == 0 ? st : (oct && k == 1) ? sw : 16'h0000};
  endfunction
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(); @(posedge i_clock) #1; endtask
  task automatic go(input logic [7:0] fc, input int rn, input logic [31:0] wd);
    response_s r;
    logic [16:0] e;
    e = model(fc, rn, wd[15:0]);
    modbus_master_model_inst.xfer(fc, rn[16:0], wd[15:0], r);
    check({r.valid, r.exception, r.data}, {1'b1, e});
    check({10'h000, o_output_channels}, {10'h000, outw[7:0]});
  endtask
  task automatic rst(input logic sel);
    i_resetn = 1'b0;
    i_module_select = sel;
    oct = sel;
    th = rnd() % 100;
    i_thumbwheel = th[6:0];
    {stl_h, outw, sw} = {1'b1, 32'h0};
    repeat (2) @(posedge i_clock);
    #1 i_resetn = 1'b1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    i_clock = 0;
    forever #12.5 i_clock = ~i_clock;
  end
  initial begin
    #50000; // Run needs about 70 cycles
    err_count++;
    test_done;
  end
  initial begin
    {i_module_type_valid, i_link_ok, tv, lnk, i_short_circuit} = {4'hF, 8'h00};
    rst(0);
    go(8'h03, hb(0), 0);
    go(8'h10, hb(1), rnd());
    go(8'h03, hb(0), 0);
    go(8'h03, hb(1), 0);
    go(8'h04, ib(0), 0);
    go(8'h04, ib(3), 0);
    go(8'h05, hb(1), 0);
    go(8'h03, hb(10), 0);
    go(8'h10, hb(-1), 32'h000000FF);
    i_module_type_valid = 1'b0;
    tv = 1'b0;
    go(8'h03, hb(0), 0);
    {i_module_type_valid, tv} = 2'b11;
    $display("relay test done");
    rst(1);
    go(8'h03, hb(0), 0);
    go(8'h04, ib(0), 0);
    repeat (6) begin
      i_short_circuit = 8'(rnd());
      sw = {14'h0, |i_short_circuit[7:4], |i_short_circuit[3:0]};
      tick();
      go(8'h04, ib(1), 0);
    end
    {i_link_ok, lnk} = 2'b00;
    tick();
    go(8'h04, ib(0), 0);
    i_short_circuit = ~i_short_circuit;
    tick();
    go(8'h04, ib(1), 0);
    go(8'h10, hb(5), rnd());
    go(8'h03, hb(0), 0);
    go(8'h03, hb(7), 0);
    go(8'h04, ib(10), 0);
    go(8'h10, hb(1), rnd());
    go(8'h04, ib(0), 0);
    {i_link_ok, lnk} = 2'b11;
    sw = {14'h0, |i_short_circuit[7:4], |i_short_circuit[3:0]};
    tick();
    go(8'h04, ib(1), 0);
    go(8'h04, ib(0), 0);
    $display("octal test done");
    test_done;
  end
endmodule // output_module_process_image_tb
`default_nettype wire

// ===== sim/process_image_chk.sv
// Purpose: Port assertions for the output module process image
// Assumes: Module kind strap changes only while in reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module process_image_chk
  import process_image_pkg::*;
(
  input wire logic                   i_clock,
  input wire logic                   i_resetn,
  input wire logic [THUMB_WIDTH-1:0] i_thumbwheel,
  input wire logic                   i_module_select,
  input wire logic                   i_module_type_valid,
  input wire logic                   i_link_ok,
  input wire logic [7:0]             i_short_circuit,
  input wire request_s               i_request,
  input wire response_s              o_response,
  input wire logic [7:0]             o_output_channels
);
  // ******
  // Group decode and write history
  // ******
  logic [16:0] off;
  logic [16:0] ib;
  logic [16:0] hb;
  logic [16:0] rn;
  logic [7:0]  fc;
  logic        rq;
  logic        wrote;
  assign off = GROUP_STRIDE * {10'h000, i_thumbwheel};
  assign ib  = INPUT_REG_BASE + off;
  assign hb  = HOLDING_REG_BASE + off;
  assign rn  = i_request.register_number;
  assign fc  = i_request.function_code;
  assign rq  = i_request.valid;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) wrote <= 1'b0;
    else if (rq && fc == FC_WRITE_MULTI && rn >= hb && rn <= hb + 17'h00009) wrote <= 1'b1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  a_resp_next: assert property (rq |=> o_response.valid)
    else $error("response missing");
  a_bad_code: assert property (rq && !(fc inside {8'h03, 8'h04, 8'h10})
    |=> o_response.exception && o_response.data == EXC_ILLEGAL_FUNC) else $error("bad code");
  a_bad_addr: assert property (rq && fc == FC_READ_HOLDING
    && (rn < hb || rn > hb + 17'h00009)
    |=> o_response.exception && o_response.data == EXC_ILLEGAL_ADDR) else $error("bad addr");
  a_type_zero: assert property (rq && fc == 8'h03 && rn == hb && !i_module_type_valid
    ##1 !i_module_type_valid |-> o_response.data[7:0] == 8'h00) else $error("type field");
  a_stale_fresh: assert property (rq && fc == 8'h03 && rn == hb && !wrote
    |=> o_response.data[STALE_BIT]) else $error("flag low early");
  a_stale_gone: assert property (rq && fc == 8'h03 && rn == hb && wrote
    |=> !o_response.data[STALE_BIT]) else $error("flag not cleared");
  a_short_word: assert property (i_module_select && rq && fc == 8'h04 && rn == ib + 17'h1
    && i_link_ok && $past(i_link_ok) && $past(i_resetn) && $stable(i_short_circuit)
    |=> o_response.data[1:0] == {|$past(i_short_circuit[7:4]), |$past(i_short_circuit[3:0])})
    else $error("short word");
  a_link_lost: assert property (i_module_select && rq && fc == 8'h04 && rn == ib
    && !$past(i_link_ok) && $past(i_resetn) |=> o_response.data[STALE_BIT]) else $error("link");
  a_write_out: assert property (rq && fc == FC_WRITE_MULTI && rn == hb + 17'h1
    |=> o_output_channels == ($past(i_request.write_data[7:0])
    & (i_module_select ? OCTAL_OUT_MASK : RELAY_OUT_MASK))) else $error("outputs");
endmodule // process_image_chk
bind output_module_process_image process_image_chk process_image_chk_inst (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_thumbwheel(i_thumbwheel),
  .i_module_select(i_module_select), .i_module_type_valid(i_module_type_valid),
  .i_link_ok(i_link_ok), .i_short_circuit(i_short_circuit), .i_request(i_request),
  .o_response(o_response), .o_output_channels(o_output_channels));
`default_nettype wire
